// ===== verilog/pew_host.sv
// Operation
// - without polling, wait full 10 ms before dependent operation
// - keep address bits 7 to 15 equal across one page
// - successive page byte loads spaced 0.2 us to 100 us
// - wait at least 10 us after a write sequence before next strobe
// - output enable may pulse with select and strobe high between loads
// - output enable low with select low, strobe high polls status
// - each page byte load is a complete strobe-timed write cycle
// - each poll is a normal read cycle with read timing
// - never assume fixed start or end value of toggle bit
`include "pew_map.svh"
module pew_host
   import pew_pkg::*;
#(
   parameter int WRITE_TIME_US = `PEW_WRITE_TIME_US,
   parameter bit USE_POLL = 1'b1
) (
   // clocking
   input wire logic clock,
   input wire logic resetn,
   input wire logic clock_en,
   // user request
   input wire pew_pkg::pew_req_t req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic page_error,
   output logic busy,
   // device pins
   output pew_pkg::pew_pins_t pins,
   input wire logic [7:0] dq_in
);
   import pew_pkg::*;
   localparam int T_STROBE = (`PEW_STROBE_NS * `PEW_CLK_MHZ + 999) / 1000;
   localparam int T_READ = (`PEW_READ_NS * `PEW_CLK_MHZ + 999) / 1000;
   localparam int T_BLC_MIN = (`PEW_BLC_MIN_NS * `PEW_CLK_MHZ + 999) / 1000;
   localparam int T_BLC_MAX = `PEW_BLC_MAX_US * `PEW_CLK_MHZ;
   localparam int T_GAP = `PEW_REWRITE_GAP_US * `PEW_CLK_MHZ;
   localparam int T_WRITE = WRITE_TIME_US * `PEW_CLK_MHZ;
   localparam int TW = 20;
   if (T_WRITE >= (1 << TW) || T_WRITE < 1)
   begin : g_bad_write_time
      $error("pew_host: write time does not fit timer");
   end

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_WSTB = 7'h02,
      S_LOAD = 7'h04,
      S_RSTB = 7'h08,
      S_POLL = 7'h10,
      S_WAIT = 7'h20,
      S_GAP = 7'h40
   } pew_state_t;

   pew_state_t state_q, state_d;
   logic [1:0] sync0_q [8];
   logic [7:0] dq_s;
   logic [7:0] prev_q;
   logic prev_v_q;
   logic in_page_q;
   logic [`PEW_PAGE_HI-`PEW_PAGE_LO:0] page_q;
   pew_pins_t pins_q;
   logic [7:0] rd_q;
   logic rdv_q, perr_q;
   logic tstart;
   logic [TW-1:0] tload;
   logic tdone;
   logic [TW-1:0] blc_q;

   // pin inputs come from an asynchronous part
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_sync
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               sync0_q[g] <= 2'h0;
            else if (clock_en)
               sync0_q[g] <= {sync0_q[g][0], dq_in[g]};
         end
         assign dq_s[g] = sync0_q[g][1];
      end
   endgenerate

   pew_timer #(.WIDTH(TW)) u_timer (
      .clock(clock),
      .resetn(resetn),
      .ce(clock_en),
      .start(tstart),
      .load(tload),
      .done(tdone)
   );

   wire [`PEW_PAGE_HI-`PEW_PAGE_LO:0] req_page = req.addr[`PEW_PAGE_HI:`PEW_PAGE_LO];
   wire page_bad = in_page_q && req.write && (req_page != page_q);
   wire blc_ok = blc_q >= TW'(T_BLC_MIN);
   wire take = req_valid && req_ready;
   // toggle bit stable twice in a row means write finished; start value not assumed
   wire poll_done = prev_v_q && (prev_q[`PEW_DQ_TOGGLE] == dq_s[`PEW_DQ_TOGGLE]);
   // reads wait for the page to close, so output enable never pulses mid-page
   assign req_ready = ((state_q == S_IDLE) || (state_q == S_LOAD && blc_ok && req.write)) && !page_bad;

   always_comb
   begin
      state_d = state_q;
      tstart = 1'b0;
      tload = '0;
      case (state_q)
         S_IDLE:
            if (take)
            begin
               state_d = req.write ? S_WSTB : S_RSTB;
               tstart = 1'b1;
               tload = req.write ? TW'(T_STROBE) : TW'(T_READ);
            end
         S_WSTB:
            if (tdone)
               state_d = S_LOAD;
         S_LOAD:
            if (take)
            begin
               state_d = S_WSTB;
               tstart = 1'b1;
               tload = TW'(T_STROBE);
            end
            else if (blc_q >= TW'(T_BLC_MAX - T_STROBE - `PEW_BLC_SLACK))
            begin
               tstart = 1'b1;
               tload = USE_POLL ? TW'(T_READ) : TW'(T_WRITE);
               state_d = USE_POLL ? S_POLL : S_WAIT;
            end
         S_RSTB:
            if (tdone)
               state_d = S_IDLE;
         S_POLL:
            if (tdone)
            begin
               tstart = 1'b1;
               if (poll_done)
               begin
                  state_d = S_GAP;
                  tload = TW'(T_GAP);
               end
               else
                  tload = TW'(T_READ);
            end
         S_WAIT:
            if (tdone)
            begin
               state_d = S_GAP;
               tstart = 1'b1;
               tload = TW'(T_GAP);
            end
         S_GAP:
            if (tdone)
               state_d = S_IDLE;
         default:
            state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= S_IDLE;
         blc_q <= '0;
         in_page_q <= 1'b0;
         page_q <= '0;
      end
      else if (clock_en)
      begin
         state_q <= state_d;
         blc_q <= (state_q == S_WSTB && tdone) ? '0 : blc_q + 1'b1;
         if (take && req.write)
            page_q <= req_page;
         in_page_q <= (state_d == S_WSTB) || (state_d == S_LOAD);
      end
   end

   // pins: select and strobe together bound each cycle, so the device
   // sees a full write or a plain read and never a mixed decode
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pins_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 16'h0000, dout: 8'h00, dq_oe: 1'b0};
         rd_q <= 8'h00;
         rdv_q <= 1'b0;
         prev_q <= 8'h00;
         prev_v_q <= 1'b0;
         perr_q <= 1'b0;
      end
      else if (clock_en)
      begin
         rdv_q <= 1'b0;
         perr_q <= req_valid && page_bad;
         if (take)
         begin
            pins_q.addr <= req.addr;
            pins_q.dout <= req.data;
         end
         pins_q.cs_n <= !(state_d == S_WSTB || state_d == S_RSTB || state_d == S_POLL);
         pins_q.we_n <= !(state_d == S_WSTB);
         pins_q.oe_n <= !(state_d == S_RSTB || state_d == S_POLL);
         pins_q.dq_oe <= (state_d == S_WSTB);
         if (state_q == S_RSTB && tdone)
         begin
            rd_q <= dq_s;
            rdv_q <= 1'b1;
         end
         if (state_q == S_POLL && tdone)
         begin
            prev_q <= dq_s;
            prev_v_q <= !poll_done;
         end
         else if (state_q != S_POLL)
            prev_v_q <= 1'b0;
      end
   end

   // strobes drop between polls so each poll is its own read cycle
   assign pins = (state_q == S_POLL && tdone) ? '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: pins_q.addr,
                 dout: pins_q.dout, dq_oe: 1'b0} : pins_q;
   assign rd_data = rd_q;
   assign rd_valid = rdv_q;
   assign page_error = perr_q;
   assign busy = state_q != S_IDLE;
endmodule : pew_host

// ===== pkg/pew_map.svh
`ifndef PEW_MAP_SVH
`define PEW_MAP_SVH
`define PEW_CLK_MHZ 50
`define PEW_WRITE_TIME_US 10000
`define PEW_BLC_MIN_NS 200
`define PEW_BLC_MAX_US 100
`define PEW_BLC_SLACK 2
`define PEW_REWRITE_GAP_US 10
`define PEW_STROBE_NS 100
`define PEW_READ_NS 250
`define PEW_PAGE_HI 15
`define PEW_PAGE_LO 7
`define PEW_DQ_TOGGLE 6
`endif

// ===== pkg/pew_pkg.sv
package pew_pkg;
   typedef struct packed {
      logic write;
      logic last;
      logic [15:0] addr;
      logic [7:0] data;
   } pew_req_t;
   typedef struct packed {
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic [15:0] addr;
      logic [7:0] dout;
      logic dq_oe;
   } pew_pins_t;
endpackage : pew_pkg

// ===== verilog/pew_timer.sv
`include "pew_map.svh"
module pew_timer #(
   parameter int WIDTH = 20
) (
   // clocking
   input wire logic clock,
   input wire logic resetn,
   input wire logic ce,
   // control
   input wire logic start,
   input wire logic [WIDTH-1:0] load,
   output logic done
);
   logic [WIDTH-1:0] cnt_q;
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         cnt_q <= '0;
      else if (ce)
      begin
         if (start)
            cnt_q <= load;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
      end
   end
   // done must not look at start: callers restart the timer on done
   assign done = (cnt_q == '0);
endmodule : pew_timer

// ===== verification/pew_props.sv
module pew_props
   import pew_pkg::*;
(
   // host pins
   input wire logic clock,
   input wire logic resetn,
   input wire pew_pkg::pew_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [12:0] we_q, oe_q;
   logic [8:0] pg_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         we_q <= '1;
         oe_q <= '1;
         pg_q <= '0;
      end
      else
      begin
         we_q <= pins.we_n ? we_q + 13'(~&we_q) : '0;
         oe_q <= pins.oe_n ? oe_q + 13'(~&oe_q) : '0;
         pg_q <= pins.we_n ? pg_q : pins.addr[15:7];
      end
   end
   sequence s_load;
      $fell(pins.we_n);
   endsequence
   a_strobe_width: assert property (s_load |-> !pins.we_n [*5]) else $error("short strobe");
   a_write_ctrl: assert property (!pins.we_n |-> !pins.cs_n && pins.oe_n && pins.dq_oe) else $error("bad write");
   a_strobe_hold: assert property (!pins.we_n && !$past(pins.we_n) |-> $stable({pins.addr, pins.dout}))
      else $error("moved");
   a_load_space: assert property (s_load ##0 we_q < 5000 |-> we_q >= 10) else $error("close loads");
   a_page_same: assert property (s_load ##0 we_q < 5000 |-> pins.addr[15:7] == pg_q) else $error("page moved");
   a_next_gap: assert property (s_load ##0 we_q >= 5000 |-> oe_q >= 500) else $error("short gap");
   a_poll_width: assert property ($fell(pins.oe_n) |-> !pins.oe_n [*5]) else $error("short read");
   a_poll_ctrl: assert property (!pins.oe_n |-> pins.we_n && !pins.dq_oe) else $error("bad read");
endmodule : pew_props

bind pew_host pew_props i_props (.clock, .resetn, .pins);

// ===== verification/pew_dev.sv
module pew_dev
   import pew_pkg::*;
#(
   parameter int SLOW_NS = 150000
) (
   // host pins
   input wire pew_pkg::pew_pins_t pins,
   // data towards the host
   output logic [7:0] dq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [15:0]];
   logic [7:0] last = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [15:0] wr_addr = 16'h0000;
   logic [7:0] dq_q = 8'h00;
   logic tog = 1'b0;
   logic wr_on = 1'b0;
   logic rd_on = 1'b0;
   time done_at = 0;
   assign dq = dq_q;
   // a load ends on whichever of select or strobe rises first, both may rise together;
   // each load restarts the internal write, odd data makes it outlast the page window
   always @(pins)
   begin
      if (!pins.cs_n && !pins.we_n && pins.oe_n)
      begin
         wr_on = 1'b1;
         wr_addr = pins.addr;
         wr_data = pins.dout;
      end
      else if (wr_on)
      begin
         wr_on = 1'b0;
         mem[wr_addr] = wr_data;
         last = wr_data;
         done_at = $time + (wr_data[0] ? SLOW_NS : 3000);
      end
      // output enable with select high leaves a page load alone
      if (!pins.cs_n && !pins.oe_n && pins.we_n)
      begin
         // the toggle is never reset, so its start value varies
         if (!rd_on && $time < done_at)
            tog = ~tog;
         rd_on = 1'b1;
         dq_q = $time < done_at ? {~last[7], tog, last[5:0]} : mem[pins.addr];
      end
      else
      begin
         // released lines flip on every pin change instead of holding
         rd_on = 1'b0;
         dq_q = ~dq_q;
      end
   end
endmodule : pew_dev

// ===== verification/test_pew_host.sv
`include "pew_map.svh"
module test_pew_host;
   timeunit 1ns;
   timeprecision 1ns;
   import pew_pkg::*;
   `define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
      $display("wrong value at %0t: %h %h", $time, a, e); end end
   localparam int WT_US = 20;
   logic clock = 0, resetn = 0, req_valid = 0, req_ready, rd_valid, page_error, busy;
   logic req_valid_w = 0, req_ready_w, rd_valid_w, busy_w;
   logic [7:0] rd_data_w, dev_dq_w, wdat;
   pew_pins_t pins_w;
   int busy_cyc;
   wire logic [7:0] dq_in_w = pins_w.dq_oe ? pins_w.dout : dev_dq_w;
   logic [7:0] rd_data, dev_dq, exp_mem [logic [15:0]];
   logic [15:0] base;
   pew_req_t req = '0;
   pew_pins_t pins;
   int bad_count = 0, total_checks = 0, errs = 0;
   wire logic [7:0] dq_in = pins.dq_oe ? pins.dout : dev_dq;
   pew_host #(.WRITE_TIME_US(WT_US)) i_dut (.clock, .resetn, .clock_en(1'b1), .req, .req_valid, .req_ready, .rd_data,
      .rd_valid, .page_error, .busy, .pins, .dq_in);
   pew_dev i_dev (.pins, .dq(dev_dq));
   // second host in wait mode: shares the request word, has its own valid
   pew_host #(.WRITE_TIME_US(WT_US), .USE_POLL(1'b0)) i_dut_wait (.clock, .resetn, .clock_en(1'b1), .req,
      .req_valid(req_valid_w), .req_ready(req_ready_w), .rd_data(rd_data_w), .rd_valid(rd_valid_w), .page_error(),
      .busy(busy_w), .pins(pins_w), .dq_in(dq_in_w));
   // its device must finish inside the host's assumed write time
   pew_dev #(.SLOW_NS(15000)) i_dev_w (.pins(pins_w), .dq(dev_dq_w));
   initial forever #10 clock = ~clock;
   always @(negedge clock) if (page_error === 1'b1) errs++;
   // page window, then the full write time, then the rewrite gap
   function automatic int exp_wait();
      return (`PEW_BLC_MAX_US + WT_US + `PEW_REWRITE_GAP_US) * `PEW_CLK_MHZ;
   endfunction : exp_wait
   task automatic test_done();
      $display("checks %0d, errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   task automatic put(input logic w, input logic [15:0] a, input logic [7:0] d, input bit wt = 1'b0);
      @(negedge clock);
      req = '{w, 1'b0, a, d};
      if (wt)
         req_valid_w = 1;
      else
         req_valid = 1;
      do @(posedge clock); while ((wt ? req_ready_w : req_ready) !== 1'b1);
      @(negedge clock);
      req_valid = 0;
      req_valid_w = 0;
      if (w && !wt)
         exp_mem[a] = d;
   endtask : put
   // wait for page close and poll end, then read every byte back
   task automatic settle();
      repeat (9000) @(negedge clock) if (busy === 1'b0) break;
      `CHK(busy, 1'b0)
      foreach (exp_mem[a])
      begin
         put(0, a, 8'h00);
         repeat (99) @(negedge clock) if (rd_valid === 1'b1) break;
         `CHK({rd_valid, rd_data}, {1'b1, exp_mem[a]})
      end
      exp_mem.delete();
      // user reads also end a sequence for the next strobe
      repeat (500) @(negedge clock);
   endtask : settle
   initial
   begin
      void'($urandom(32'h2036));
      repeat (20) @(negedge clock);
      resetn = 1;
      // wait mode: one byte, no polling, then read it back
      base = 16'($urandom);
      wdat = 8'($urandom);
      put(1, base, wdat, 1'b1);
      busy_cyc = 0;
      while (busy_w === 1'b1 && busy_cyc < 20000)
      begin
         @(negedge clock);
         busy_cyc++;
      end
      `CHK(busy_cyc >= exp_wait() - 20, 1'b1)
      `CHK(busy_cyc <= exp_wait() + 20, 1'b1)
      put(0, base, 8'h00, 1'b1);
      repeat (99) @(negedge clock) if (rd_valid_w === 1'b1) break;
      `CHK({rd_valid_w, rd_data_w}, {1'b1, wdat})
      // one page, random spacing, first and last byte included
      base = 16'($urandom) & 16'hff80;
      for (int i = 0; i < 127; i += 1 + int'($urandom % 30))
         put(1, base + 16'(i), 8'($urandom));
      // odd last byte keeps the device busy past the window, so polls see the toggle
      put(1, base | 16'h007f, 8'($urandom) | 8'h01);
      settle();
      // a byte for another page while this one is loading
      put(1, base, 8'($urandom));
      put(1, base ^ 16'h0080, 8'($urandom));
      `CHK(errs > 0, 1'b1)
      settle();
      test_done();
   end
   // about twice the longest expected run
   initial
   begin
      #1400000;
      bad_count++;
      test_done();
   end
endmodule : test_pew_host
